/* File: core/pkt_sizer_pkg.sv */
// Purpose: Shared constants and types for the isochronous packet sizer
// Assumes: 10 MHz mclk, 32-bit stream words carrying four payload bytes each
// Notes:   Bit positions in status words are numbered with bit 0 as the MSB

package pkt_sizer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned BUS_CYCLE_NS   = 125000;
  localparam int unsigned BUS_CYCLE_CLKS = BUS_CYCLE_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = $clog2(BUS_CYCLE_CLKS);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(BUS_CYCLE_CLKS - 1);

  // ----------------------------------------------------------------
  // Payload sizing
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned PAYLOAD_W  = 14;
  localparam int unsigned PWORDS_W   = PAYLOAD_W - 2;
  localparam logic [PAYLOAD_W-1:0] LIMIT_S400    = 14'h1000;
  localparam logic [PAYLOAD_W-1:0] LIMIT_S800    = 14'h2000;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_MIN   = 14'h0004;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_RESET = 14'h1000;
  localparam int unsigned IMG_BYTES_W  = 24;
  localparam int unsigned FRAME_CYC_W  = 16;
  localparam int unsigned DIV_W        = 24;

  // ----------------------------------------------------------------
  // Inquiry address space
  // ----------------------------------------------------------------
  localparam int unsigned BUS_ID_W   = 10;
  localparam int unsigned NODE_ID_W  = 6;
  localparam int unsigned INQ_OFS_W  = 12;
  localparam logic [47:0] INQ_BASE_LOW = 48'hffff_f0f0_0000;

  // ----------------------------------------------------------------
  // Status word, bit 0 is the MSB
  // ----------------------------------------------------------------
  localparam int unsigned ST_BIT_S800    = 0;
  localparam int unsigned ST_BIT_LIMITED = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } send_state_t;

  typedef struct packed {
    logic              last;
    logic [DATA_W-1:0] data;
  } word_t;

  function automatic int unsigned msb0_pos(input int unsigned n);
    return 31 - n;
  endfunction

  function automatic logic [63:0] inquiry_address(
    input logic [BUS_ID_W-1:0]  bus_id,
    input logic [NODE_ID_W-1:0] node_id,
    input logic [INQ_OFS_W-1:0] offset
  );
    return {bus_id, node_id, INQ_BASE_LOW + {36'h0, offset}};
  endfunction

endpackage

/* File: core/word_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Flags are registered so s_ready and m_valid come straight from flops

`timescale 1ns/1ps
`default_nettype none

module word_fifo
#(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 16
)
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             s_valid,
  output var  logic             s_ready,
  input  wire logic [WIDTH-1:0] s_data,
  output var  logic             m_valid,
  input  wire logic             m_ready,
  output var  logic [WIDTH-1:0] m_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             next_s_ready;
  logic             next_m_valid;
  logic             push;
  logic             pop;
  logic [AW:0]      fill;

  always_comb
  begin
    push        = s_valid && s_ready;
    pop         = m_valid && m_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    fill        = next_wr_ptr - next_rd_ptr;
    // Full and empty from the pointers that will hold next cycle
    next_s_ready = fill != (AW+1)'(DEPTH);
    next_m_valid = fill != '0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      s_ready <= 1'b0;
      m_valid <= 1'b0;
    end
    else
    begin
      wr_ptr  <= next_wr_ptr;
      rd_ptr  <= next_rd_ptr;
      s_ready <= next_s_ready;
      m_valid <= next_m_valid;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= s_data;
    end
  end

  assign m_data = mem[rd_ptr[AW-1:0]];

endmodule

`default_nettype wire

/* File: core/ceil_divider.sv */
// Purpose: Sequential divider returning the quotient rounded up
// Assumes: start pulses only while idle; operands are sampled at start
// Notes:   W+1 cycles per result; a zero divisor yields all ones

`timescale 1ns/1ps
`default_nettype none

module ceil_divider
#(
  parameter int unsigned W = 24
)
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output var  logic         done,
  output var  logic [W-1:0] quot
);

  localparam int unsigned CW = $clog2(W + 2);

  logic [W:0]    rem;
  logic [W:0]    quo;
  logic [W:0]    dd;
  logic [CW-1:0] cnt;
  logic [W:0]    next_rem;
  logic [W:0]    next_quo;
  logic [W:0]    next_dd;
  logic [CW-1:0] next_cnt;
  logic          next_done;
  logic [W:0]    shifted;

  always_comb
  begin
    next_rem  = rem;
    next_quo  = quo;
    next_dd   = dd;
    next_cnt  = cnt;
    next_done = 1'b0;
    shifted   = {rem[W-1:0], quo[W]};
    if (start)
    begin
      // Adding den-1 first turns floor division into ceiling division
      next_quo = {1'b0, num} + {1'b0, den} - (W+1)'(1);
      next_rem = '0;
      next_dd  = {1'b0, den};
      next_cnt = CW'(W + 1);
    end
    else if (cnt != '0)
    begin
      if (shifted >= dd)
      begin
        next_rem = shifted - dd;
        next_quo = {quo[W-1:0], 1'b1};
      end
      else
      begin
        next_rem = shifted;
        next_quo = {quo[W-1:0], 1'b0};
      end
      next_cnt  = cnt - CW'(1);
      next_done = cnt == CW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rem  <= '0;
      quo  <= '0;
      dd   <= '0;
      cnt  <= '0;
      done <= 1'b0;
    end
    else
    begin
      rem  <= next_rem;
      quo  <= next_quo;
      dd   <= next_dd;
      cnt  <= next_cnt;
      done <= next_done;
    end
  end

  assign quot = quo[W] ? '1 : quo[W-1:0];

endmodule

`default_nettype wire

/* File: core/isochronous_packet_sizer.sv */
// Purpose: Cuts an image word stream into one isochronous packet per bus cycle
// Assumes: One payload byte lane per byte of a 32-bit word; host honours bus shares
// Notes:   Speed follows device and path capability pins; payload kept rate-legal

`timescale 1ns/1ps
`default_nettype none

module isochronous_packet_sizer
  import pkt_sizer_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   in_valid,
  output var  logic                   in_ready,
  input  wire logic [DATA_W-1:0]      in_data,
  input  wire logic                   in_last,
  output var  logic                   out_valid,
  input  wire logic                   out_ready,
  output var  logic [DATA_W-1:0]      out_data,
  output var  logic                   out_first,
  output var  logic                   out_last,
  output var  logic                   out_cut,
  output var  logic                   cycle_tick,
  input  wire logic                   cap_local_b,
  input  wire logic                   cap_path_b,
  output var  logic                   s800_active,
  input  wire logic                   cfg_write,
  input  wire logic [PAYLOAD_W-1:0]   cfg_payload,
  output var  logic [PAYLOAD_W-1:0]   payload,
  output var  logic                   cfg_reject,
  input  wire logic [IMG_BYTES_W-1:0] image_bytes,
  input  wire logic [FRAME_CYC_W-1:0] frame_cycles,
  output var  logic [PAYLOAD_W-1:0]   recommended_payload,
  output var  logic                   rate_limited,
  output var  logic [FRAME_CYC_W-1:0] frame_period_limit,
  output var  logic [FRAME_CYC_W-1:0] image_cycles,
  output var  logic [31:0]            status_word,
  input  wire logic [BUS_ID_W-1:0]    bus_id,
  input  wire logic [NODE_ID_W-1:0]   node_id,
  input  wire logic                   req_valid,
  input  wire logic [63:0]            req_addr,
  output var  logic [63:0]            inquiry_base,
  output var  logic                   addr_hit,
  output var  logic [INQ_OFS_W-1:0]   addr_offset
);

  // ----------------------------------------------------------------
  // Capability pins, two flops each
  // ----------------------------------------------------------------
  logic [1:0] local_b_sync;
  logic [1:0] path_b_sync;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      local_b_sync <= 2'b00;
      path_b_sync  <= 2'b00;
    end
    else
    begin
      local_b_sync <= {local_b_sync[0], cap_local_b};
      path_b_sync  <= {path_b_sync[0], cap_path_b};
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle timer
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic              next_cycle_tick;

  always_comb
  begin
    next_tick_cnt   = (tick_cnt == TICK_LAST) ? '0 : tick_cnt + TICK_W'(1);
    next_cycle_tick = tick_cnt == TICK_LAST;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt   <= '0;
      cycle_tick <= 1'b0;
    end
    else
    begin
      tick_cnt   <= next_tick_cnt;
      cycle_tick <= next_cycle_tick;
    end
  end

  // ----------------------------------------------------------------
  // Speed and payload setting
  // ----------------------------------------------------------------
  logic                 next_s800;
  logic [PAYLOAD_W-1:0] limit;
  logic [PAYLOAD_W-1:0] next_payload;
  logic                 next_cfg_reject;
  logic                 cfg_ok;

  always_comb
  begin
    next_s800 = local_b_sync[1] && path_b_sync[1];
    limit     = s800_active ? LIMIT_S800 : LIMIT_S400;
    cfg_ok    = (cfg_payload[1:0] == 2'b00)
             && (cfg_payload >= PAYLOAD_MIN)
             && (cfg_payload <= limit);
    next_payload    = payload;
    next_cfg_reject = cfg_write && !cfg_ok;
    if (cfg_write && cfg_ok)
    begin
      next_payload = cfg_payload;
    end
    else if (payload > limit)
    begin
      // Falling back to S400 must not leave an S800-sized packet behind
      next_payload = limit;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s800_active <= 1'b0;
      payload     <= PAYLOAD_RESET;
      cfg_reject  <= 1'b0;
    end
    else
    begin
      s800_active <= next_s800;
      payload     <= next_payload;
      cfg_reject  <= next_cfg_reject;
    end
  end

  // ----------------------------------------------------------------
  // Data buffer
  // ----------------------------------------------------------------
  word_t in_word;
  word_t head;
  logic  head_valid;
  logic  head_take;

  assign in_word = '{last: in_last, data: in_data};

  word_fifo #(
    .WIDTH ($bits(word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk    (mclk),
    .rst     (rst),
    .s_valid (in_valid),
    .s_ready (in_ready),
    .s_data  (in_word),
    .m_valid (head_valid),
    .m_ready (head_take),
    .m_data  (head)
  );

  // ----------------------------------------------------------------
  // Packet sender
  // ----------------------------------------------------------------
  send_state_t          state;
  send_state_t          next_state;
  logic [PWORDS_W:0]    words_left;
  logic [PWORDS_W:0]    next_words_left;
  logic                 first_pending;
  logic                 next_first_pending;
  logic [FRAME_CYC_W-1:0] pkt_count;
  logic [FRAME_CYC_W-1:0] next_pkt_count;
  logic [FRAME_CYC_W-1:0] next_image_cycles;
  logic                 next_out_valid;
  logic [DATA_W-1:0]    next_out_data;
  logic                 next_out_first;
  logic                 next_out_last;
  logic                 next_out_cut;
  logic                 word_last;

  always_comb
  begin
    next_state         = state;
    next_words_left    = words_left;
    next_first_pending = first_pending;
    next_pkt_count     = pkt_count;
    next_image_cycles  = image_cycles;
    next_out_valid     = out_valid && !out_ready;
    next_out_data      = out_data;
    next_out_first     = out_first;
    next_out_last      = out_last;
    next_out_cut       = 1'b0;
    word_last          = 1'b0;
    head_take          = 1'b0;
    case (state)
      ST_IDLE:
      begin
        head_take = 1'b0;
      end
      ST_SEND:
      begin
        // No word moves on a tick so a packet never straddles two cycles
        head_take = head_valid && (!out_valid || out_ready)
                 && (words_left != '0) && !cycle_tick;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (head_take)
    begin
      word_last          = (words_left == (PWORDS_W+1)'(1)) || head.last;
      next_out_valid     = 1'b1;
      next_out_data      = head.data;
      next_out_first     = first_pending;
      next_out_last      = word_last;
      next_first_pending = 1'b0;
      next_words_left    = words_left - (PWORDS_W+1)'(1);
      if (first_pending)
      begin
        next_pkt_count = pkt_count + FRAME_CYC_W'(1);
      end
      if (head.last)
      begin
        next_image_cycles = first_pending ? pkt_count + FRAME_CYC_W'(1) : pkt_count;
        next_pkt_count    = '0;
      end
      if (word_last)
      begin
        next_state = ST_IDLE;
      end
    end
    if (cycle_tick)
    begin
      // An unfinished packet is closed by the cut flag, not by a late last
      next_out_cut       = (state == ST_SEND) && !first_pending;
      next_state         = ST_SEND;
      next_words_left    = {1'b0, payload[PAYLOAD_W-1:2]};
      next_first_pending = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state         <= ST_IDLE;
      words_left    <= '0;
      first_pending <= 1'b0;
      pkt_count     <= '0;
      image_cycles  <= '0;
      out_valid     <= 1'b0;
      out_data      <= '0;
      out_first     <= 1'b0;
      out_last      <= 1'b0;
      out_cut       <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      words_left    <= next_words_left;
      first_pending <= next_first_pending;
      pkt_count     <= next_pkt_count;
      image_cycles  <= next_image_cycles;
      out_valid     <= next_out_valid;
      out_data      <= next_out_data;
      out_first     <= next_out_first;
      out_last      <= next_out_last;
      out_cut       <= next_out_cut;
    end
  end

  // ----------------------------------------------------------------
  // Recommended payload and frame period bound
  // ----------------------------------------------------------------
  logic [IMG_BYTES_W:0] bytes_round;
  logic [DIV_W-1:0]     div_num;
  logic [DIV_W-1:0]     div_den;
  logic [DIV_W-1:0]     div_quot;
  logic                 div_done;
  logic                 div_start;
  logic                 job_rec;
  logic                 next_div_start;
  logic                 next_job_rec;
  logic [PAYLOAD_W-1:0] next_recommended;
  logic                 next_rate_limited;
  logic [FRAME_CYC_W-1:0] min_frame;
  logic [FRAME_CYC_W-1:0] next_min_frame;
  logic [FRAME_CYC_W-1:0] next_frame_limit;
  logic [DIV_W-1:0]     rec_words;

  always_comb
  begin
    bytes_round = {1'b0, image_bytes} + (IMG_BYTES_W+1)'(3);
    div_num     = DIV_W'(bytes_round[IMG_BYTES_W:2]);
    // Two jobs share one divider, alternating after each result
    div_den     = job_rec ? DIV_W'(frame_cycles) : DIV_W'(payload[PAYLOAD_W-1:2]);
    next_div_start   = div_done;
    next_job_rec     = div_done ? !job_rec : job_rec;
    next_recommended = recommended_payload;
    next_min_frame   = min_frame;
    rec_words        = div_quot;
    if (div_done && job_rec)
    begin
      if (rec_words > DIV_W'(limit[PAYLOAD_W-1:2]))
      begin
        next_recommended = limit;
      end
      else if (rec_words == '0)
      begin
        next_recommended = PAYLOAD_MIN;
      end
      else
      begin
        next_recommended = {rec_words[PWORDS_W-1:0], 2'b00};
      end
    end
    if (div_done && !job_rec)
    begin
      next_min_frame = (div_quot > DIV_W'({FRAME_CYC_W{1'b1}}))
                     ? '1 : div_quot[FRAME_CYC_W-1:0];
    end
    next_rate_limited = payload < recommended_payload;
    next_frame_limit  = (min_frame > frame_cycles) ? min_frame : frame_cycles;
  end

  ceil_divider #(
    .W (DIV_W)
  ) u_div (
    .mclk  (mclk),
    .rst   (rst),
    .start (div_start),
    .num   (div_num),
    .den   (div_den),
    .done  (div_done),
    .quot  (div_quot)
  );

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_start           <= 1'b1;
      job_rec             <= 1'b1;
      recommended_payload <= PAYLOAD_MIN;
      min_frame           <= '0;
      rate_limited        <= 1'b0;
      frame_period_limit  <= '0;
    end
    else
    begin
      div_start           <= next_div_start;
      job_rec             <= next_job_rec;
      recommended_payload <= next_recommended;
      min_frame           <= next_min_frame;
      rate_limited        <= next_rate_limited;
      frame_period_limit  <= next_frame_limit;
    end
  end

  // ----------------------------------------------------------------
  // Status word and inquiry address decode
  // ----------------------------------------------------------------
  logic [31:0]          next_status;
  logic [63:0]          next_base;
  logic                 next_hit;
  logic [INQ_OFS_W-1:0] next_offset;

  always_comb
  begin
    next_status = {18'h0, recommended_payload};
    next_status[msb0_pos(ST_BIT_S800)]    = s800_active;
    next_status[msb0_pos(ST_BIT_LIMITED)] = rate_limited;
    next_base   = inquiry_address(bus_id, node_id, '0);
    // The offset window is 4 KB, so only the low bits may differ from the base
    next_hit    = req_valid && (req_addr[63:INQ_OFS_W] == next_base[63:INQ_OFS_W]);
    next_offset = next_hit ? req_addr[INQ_OFS_W-1:0] : addr_offset;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      status_word  <= '0;
      inquiry_base <= '0;
      addr_hit     <= 1'b0;
      addr_offset  <= '0;
    end
    else
    begin
      status_word  <= next_status;
      inquiry_base <= next_base;
      addr_hit     <= next_hit;
      addr_offset  <= next_offset;
    end
  end

endmodule

`default_nettype wire

/* File: tb/pkt_sizer_props.sv */
// Purpose: Port assertions for isochronous_packet_sizer
// Assumes: Cap pins reach s800_active through three flops
// Notes:   Pin checks wait four cycles to cover that latency
`timescale 1ns/1ps
`default_nettype none
module pkt_sizer_props
  import pkt_sizer_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
)
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cycle_tick,
  input wire logic        cap_local_b,
  input wire logic        cap_path_b,
  input wire logic        s800_active,
  input wire logic        cfg_write,
  input wire logic [13:0] cfg_payload,
  input wire logic [13:0] payload,
  input wire logic        cfg_reject
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  logic [10:0] gap;
  logic        seen;
  // Spacing is only known once a first tick was seen
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      gap  <= 11'h0;
      seen <= 1'b0;
    end
    else
    begin
      gap  <= cycle_tick ? 11'h0 : gap + 11'h1;
      seen <= seen | cycle_tick;
    end
  property p_tick; seen |-> cycle_tick == (gap == 11'h4e1); endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_fast; (cap_local_b && cap_path_b) [*4] |=> s800_active; endproperty
  a_fast: assert property (p_fast) else $error("no fast rate");
  property p_slow; !cap_path_b [*4] |=> !s800_active; endproperty
  a_slow: assert property (p_slow) else $error("fast on slow path");
  property p_mult; payload[1:0] == 2'h0 && payload != 14'h0; endproperty
  a_mult: assert property (p_mult) else $error("payload not whole words");
  property p_cap; !s800_active [*3] |-> payload <= LIMIT_S400; endproperty
  a_cap: assert property (p_cap) else $error("payload over slow limit");
  property p_rej;
    cfg_write && cfg_payload[1:0] != 2'h0 |=> cfg_reject && $stable(payload);
  endproperty
  a_rej: assert property (p_rej) else $error("odd size taken");
  property p_big;
    s800_active && cfg_write && cfg_payload > LIMIT_S800 |=> cfg_reject && $stable(payload);
  endproperty
  a_big: assert property (p_big) else $error("oversize taken");
  property p_acc;
    cfg_write && cfg_payload[1:0] == 2'h0 && cfg_payload != 14'h0 && cfg_payload <= LIMIT_S400
      |=> !cfg_reject && payload == $past(cfg_payload);
  endproperty
  a_acc: assert property (p_acc) else $error("legal size lost");
  c_tick: cover property (cycle_tick);
  c_rej: cover property (cfg_reject);
  c_fast: cover property (s800_active);
endmodule
bind isochronous_packet_sizer pkt_sizer_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.mclk,
  .rst, .cycle_tick, .cap_local_b, .cap_path_b, .s800_active, .cfg_write, .cfg_payload,
  .payload, .cfg_reject);
`default_nettype wire

/* File: tb/host_sink.sv */
// Purpose: Host adapter model taking the packet stream
// Assumes: Word k carries k as its data; full packets are two words
// Notes:   stall holds ready low so the FIFO backs up
`timescale 1ns/1ps
`default_nettype none
module host_sink
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        out_first,
  input  wire logic        out_last,
  output var  logic        out_ready,
  output var  logic [15:0] n_words,
  output var  logic [15:0] n_pkts,
  output var  logic [15:0] n_bad,
  output var  logic [15:0] max_len
);
  logic [15:0] len;
  logic [15:0] nlen;
  assign out_ready = !stall;
  assign nlen = out_first ? 16'h1 : len + 16'h1;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      {n_words, n_pkts, n_bad, max_len, len} <= '0;
    else if (out_valid && out_ready)
    begin
      n_words <= n_words + 16'h1;
      n_pkts  <= n_pkts + 16'(out_first);
      n_bad   <= n_bad + 16'(out_data != 32'(n_words)) + 16'(out_last != (nlen == 16'h2));
      len     <= nlen;
      max_len <= nlen > max_len ? nlen : max_len;
    end
endmodule
`default_nettype wire

/* File: tb/tb_isochronous_packet_sizer.sv */
// Purpose: Self-checking bench for isochronous_packet_sizer
// Assumes: 400-byte image in 10 bus cycles, so 100 words
// Notes:   Stream test spans about ten 1250-clock bus cycles
`timescale 1ns/1ps
`default_nettype none
module tb_isochronous_packet_sizer;
  import pkt_sizer_pkg::*;
  logic        mclk = '0, rst = 1'b1, in_valid = '0, in_last = '0, stall = '0;
  logic        cap_local_b = '0, cap_path_b = '0, cfg_write = '0, req_valid = '0;
  logic [31:0] in_data = '0, out_data, status_word;
  logic [13:0] cfg_payload = '0, payload, recommended_payload, exp_pl = 14'h1000;
  logic [63:0] req_addr = '0, inquiry_base, base = {10'h2a5, 6'h13, 48'hffff_f0f0_0000};
  logic [15:0] frame_period_limit, image_cycles, n_words, n_pkts, n_bad, max_len;
  logic [11:0] addr_offset;
  logic        in_ready, out_valid, out_ready, out_first, cycle_tick, out_last, out_cut;
  logic        s800_active, cfg_reject, rate_limited, addr_hit, r;
  int          n_mismatch = 0, cmp_count = 0, w = 0;
  isochronous_packet_sizer u_dut (.mclk, .rst, .in_valid, .in_ready, .in_data, .in_last,
    .out_valid, .out_ready, .out_data, .out_first, .out_last, .out_cut, .cycle_tick,
    .cap_local_b, .cap_path_b, .s800_active, .cfg_write, .cfg_payload, .payload, .cfg_reject,
    .image_bytes(24'h000190), .frame_cycles(16'h000a), .recommended_payload, .rate_limited,
    .frame_period_limit, .image_cycles, .status_word, .bus_id(10'h2a5), .node_id(6'h13),
    .req_valid, .req_addr, .inquiry_base, .addr_hit, .addr_offset);
  host_sink u_sink (.mclk, .rst, .stall, .out_valid, .out_data, .out_first, .out_ready,
    .out_last, .n_words, .n_pkts, .n_bad, .max_len);
  initial forever #50 mclk = ~mclk;
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cfg(input logic [13:0] v);
    logic ok, rj;
    ok = v[1:0] == 2'h0 && v != 14'h0 && v <= (cap_path_b ? LIMIT_S800 : LIMIT_S400);
    @(posedge mclk);
    cfg_write <= 1'b1;
    cfg_payload <= v;
    @(posedge mclk);
    cfg_write <= 1'b0;
    #1 rj = cfg_reject;
    @(posedge mclk);
    #1 rj = rj | cfg_reject;
    if (ok)
      exp_pl = v;
    check(rj, !ok);
    check(payload, exp_pl);
  endtask
  task automatic t_speed();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      {cap_local_b, cap_path_b} <= i[1:0];
      repeat (5) @(posedge mclk);
      #1 check(s800_active, i == 3);
      check(status_word[31], i == 3);
    end
    $display("speed test done");
  endtask
  task automatic t_cfg();
    logic [13:0] v [8] = '{14'h0664, 14'h0665, 14'h0001, 14'h0000,
                           14'h1330, 14'h2004, 14'h1000, 14'h2000};
    foreach (v[i]) cfg(v[i]);
    @(posedge mclk);
    cap_path_b <= 1'b0;
    repeat (6) @(posedge mclk);
    exp_pl = 14'h1000;
    #1 check(payload, exp_pl);
    foreach (v[i]) cfg(v[i]);
    $display("config test done");
  endtask
  task automatic t_rec();
    // 100 words in 10 cycles needs 40-byte packets; smaller ones stretch the frame
    logic [13:0] pl [3] = '{14'h0008, 14'h0014, 14'h0028};
    logic [15:0] fp [3] = '{16'h0032, 16'h0014, 16'h000a};
    for (int i = 0; i < 3; i++)
    begin
      cfg(pl[i]);
      repeat (90) @(posedge mclk);
      #1 check(recommended_payload, 14'h0028);
      check(rate_limited, i < 2);
      check(frame_period_limit, fp[i]);
      check(status_word[13:0], 14'h0028);
    end
    $display("recommend test done");
  endtask
  task automatic req(input logic [63:0] a, input logic hit);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_addr <= a;
    @(posedge mclk);
    req_valid <= 1'b0;
    #1 check(addr_hit, hit);
    if (hit)
      check(addr_offset, a[11:0]);
  endtask
  task automatic t_stream();
    cfg(14'h0008); // small share leaves the host within one cycle
    repeat (1300)
    begin
      @(posedge mclk);
      #1;
      if (cycle_tick)
        break;
    end
    @(posedge mclk);
    stall <= 1'b1;
    in_valid <= 1'b1;
    in_data <= '0;
    // Fill until the FIFO refuses
    for (int k = 0; k < 40; k++)
    begin
      #1 r = in_ready;
      @(posedge mclk);
      if (!r)
        break;
      w++;
      in_data <= 32'(w);
    end
    check(r, 1'b0);
    in_last <= 1'b1;
    stall <= 1'b0;
    do
    begin
      #1 r = in_ready;
      @(posedge mclk);
    end
    while (!r);
    in_valid <= 1'b0;
    in_last <= 1'b0;
    w++;
    for (int k = 0; k < 15000 && n_words != 16'(w); k++) @(posedge mclk);
    repeat (5) @(posedge mclk);
    #1 check(n_words, w);
    check(n_bad, 0);
    check(max_len, 2);
    check(n_pkts, (w + 1) / 2);
    check(image_cycles, (w + 1) / 2);
    in_valid <= 1'b1;
    in_data <= 32'(w);
    @(posedge mclk);
    in_valid <= 1'b0;
    r = 1'b0;
    repeat (2600) @(posedge mclk) #1 r = r | out_cut;
    check(r, 1'b1);
    $display("stream test done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check(inquiry_base, base);
    t_speed();
    t_cfg();
    t_rec();
    req(base + 64'h100, 1'b1);
    req(base + 64'h19c, 1'b1);
    req(base - 64'h4, 1'b0);
    req(base + 64'h1000, 1'b0);
    $display("address test done");
    t_stream();
    end_sim();
  end
endmodule
`default_nettype wire
